// ### verilog/sbc_top.sv
// serial interface pattern-test counters, status and control registers
`timescale 1ns/1ps
`default_nettype none
module sbc_top (
  input wire logic ref_clk, // 200 MHz system clock
  input wire logic resetn, // async reset, active low
  input wire logic [7:0] cpu_addr, // register byte address
  input wire logic [7:0] cpu_wdata, // write data
  input wire logic cpu_wr, // write strobe, one cycle
  input wire logic cpu_rd, // read strobe, one cycle
  output logic [7:0] cpu_rdata, // read data, valid cycle after cpu_rd
  input wire logic perf_monitor_update, // update control from the far side
  output logic perf_monitor_update_done, // refresh complete status
  input wire logic pattern_locked, // receive checker locked
  input wire logic rx_bit_valid, // one received bit this cycle
  input wire logic rx_bit_error, // that bit was in error
  output logic pattern_sync_lost, // checker not locked
  input wire logic rx_ser_bit, // received serial data bit
  input wire logic rx_ser_valid, // received bit valid
  input wire logic tx_pkt_bit, // transmit bit from packet queue
  input wire logic tx_pkt_valid, // transmit bit valid from queue
  output logic tx_ser_bit, // bit to serial transmitter
  output logic tx_ser_valid, // transmitter bit valid
  output logic eth_rx_bit, // received bit toward Ethernet side
  output logic eth_rx_valid, // Ethernet-side bit valid
  output logic queue_hold, // stall buffered packet release
  output logic datapath_reset // interface datapath reset, active high
);
  import sbc_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0] reset_ctrl;
  logic [7:0] loop_ctrl;
  logic [7:0] next_rdata;
  logic [ERR_W-1:0] err_shown;
  logic [BIT_W-1:0] bits_shown;
  logic [$clog2(RESET_MIN_CYC+1)-1:0] rst_hold;
  logic pmu_sync;
  logic pmu_prev;
  logic pmu_rise;
  logic snap;
  logic sync_lost_now;
  logic err_event;
  logic err_nonzero;
  logic err_nonzero_prev;
  logic done_prev;
  logic sync_lost_prev;
  logic lat_done;
  logic lat_err_seen;
  logic lat_nonzero;
  logic lat_sync;
  logic rd_latched;
  logic dp_rst;
  logic loop_on;
  sbc_pm_state_t pm_state;
  sbc_pm_state_t next_pm_state;

  // ****************************************************************
  // software reset of the interface datapath
  // ****************************************************************
  // stretch keeps the reset valid even if software drops the bit early
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_hold <= '0;
    end else if (reset_ctrl[RESET_CTRL_BIT]) begin
      rst_hold <= ($bits(rst_hold))'(RESET_MIN_CYC);
    end else if (rst_hold != '0) begin
      rst_hold <= rst_hold - 1'b1;
    end
  end

  assign dp_rst = reset_ctrl[RESET_CTRL_BIT] || (rst_hold != '0);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      datapath_reset <= 1'b1;
    end else begin
      datapath_reset <= dp_rst;
    end
  end

  // ****************************************************************
  // update control edge detect
  // ****************************************************************
  sbc_sync2 u_pmu_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .din(perf_monitor_update),
    .dout(pmu_sync)
  );

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pmu_prev <= 1'b0;
    end else begin
      pmu_prev <= pmu_sync;
    end
  end

  assign pmu_rise = pmu_sync && !pmu_prev;

  // ****************************************************************
  // refresh sequencer
  // ****************************************************************
  always_comb begin
    next_pm_state = pm_state;
    unique case (pm_state)
      PM_IDLE: begin
        if (pmu_rise) begin
          next_pm_state = PM_LOAD;
        end
      end
      PM_LOAD: begin
        next_pm_state = PM_ZERO;
      end
      PM_ZERO: begin
        next_pm_state = PM_DONE;
      end
      PM_DONE: begin
        next_pm_state = PM_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pm_state <= PM_IDLE;
    end else if (dp_rst) begin
      pm_state <= PM_IDLE;
    end else begin
      pm_state <= next_pm_state;
    end
  end

  // copy and clear happen together in one cycle
  assign snap = (pm_state == PM_LOAD);

  // done stays low through load and zero, set on the closing step
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      perf_monitor_update_done <= 1'b0;
    end else if (dp_rst) begin
      perf_monitor_update_done <= 1'b0;
    end else if (!pmu_sync) begin
      // follows the control low one cycle after the synchroniser
      perf_monitor_update_done <= 1'b0;
    end else if (pmu_rise || pm_state != PM_IDLE && pm_state != PM_DONE) begin
      perf_monitor_update_done <= 1'b0;
    end else if (pm_state == PM_DONE) begin
      perf_monitor_update_done <= 1'b1;
    end
  end

  // ****************************************************************
  // pattern tallies
  // ****************************************************************
  assign sync_lost_now = !pattern_locked;
  assign err_event = rx_bit_valid && rx_bit_error;

  sbc_sat_counter #(
    .W(ERR_W)
  ) u_err_tally (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clr(dp_rst),
    .inc(err_event),
    .freeze(sync_lost_now),
    .snap(snap),
    .shown(err_shown)
  );

  sbc_sat_counter #(
    .W(BIT_W)
  ) u_bit_tally (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clr(dp_rst),
    .inc(rx_bit_valid),
    .freeze(sync_lost_now),
    .snap(snap),
    .shown(bits_shown)
  );

  // ****************************************************************
  // live status
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pattern_sync_lost <= 1'b0;
    end else if (dp_rst) begin
      pattern_sync_lost <= 1'b0;
    end else begin
      pattern_sync_lost <= sync_lost_now;
    end
  end

  // zero-count status is forced low for exactly the zero step
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      err_nonzero <= 1'b0;
    end else if (dp_rst || pm_state == PM_ZERO) begin
      err_nonzero <= 1'b0;
    end else begin
      err_nonzero <= (err_shown != '0);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      err_nonzero_prev <= 1'b0;
      done_prev <= 1'b0;
      sync_lost_prev <= 1'b0;
    end else begin
      err_nonzero_prev <= err_nonzero;
      done_prev <= perf_monitor_update_done;
      sync_lost_prev <= pattern_sync_lost;
    end
  end

  // ****************************************************************
  // latched status, cleared by reading
  // ****************************************************************
  assign rd_latched = cpu_rd && (cpu_addr == ADDR_LATCHED);

  // a new event in the read cycle wins over the clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lat_done <= 1'b0;
      lat_err_seen <= 1'b0;
      lat_nonzero <= 1'b0;
      lat_sync <= 1'b0;
    end else if (dp_rst) begin
      lat_done <= 1'b0;
      lat_err_seen <= 1'b0;
      lat_nonzero <= 1'b0;
      lat_sync <= 1'b0;
    end else begin
      if (perf_monitor_update_done && !done_prev) begin
        lat_done <= 1'b1;
      end else if (rd_latched) begin
        lat_done <= 1'b0;
      end
      if (err_event) begin
        lat_err_seen <= 1'b1;
      end else if (rd_latched) begin
        lat_err_seen <= 1'b0;
      end
      if (err_nonzero && !err_nonzero_prev) begin
        lat_nonzero <= 1'b1;
      end else if (rd_latched) begin
        lat_nonzero <= 1'b0;
      end
      if (pattern_sync_lost != sync_lost_prev) begin
        lat_sync <= 1'b1;
      end else if (rd_latched) begin
        lat_sync <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // writable control registers
  // ****************************************************************
  // only defined bits store; reserved bits stay zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reset_ctrl <= REG_RESET_VAL;
    end else if (cpu_wr && cpu_addr == ADDR_RESET_CTRL) begin
      reset_ctrl <= REG_RESET_VAL;
      reset_ctrl[RESET_CTRL_BIT] <= cpu_wdata[RESET_CTRL_BIT];
    end
  end

  // the loopback control itself is outside the datapath reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      loop_ctrl <= REG_RESET_VAL;
    end else if (cpu_wr && cpu_addr == ADDR_LOOP_CTRL) begin
      loop_ctrl <= REG_RESET_VAL;
      loop_ctrl[LOOP_CTRL_BIT] <= cpu_wdata[LOOP_CTRL_BIT];
    end
  end

  assign loop_on = loop_ctrl[LOOP_CTRL_BIT];

  // ****************************************************************
  // read mux
  // ****************************************************************
  // writes to tally and status addresses have no path to storage
  always_comb begin
    next_rdata = 8'h00;
    unique case (cpu_addr)
      ADDR_STATUS: begin
        next_rdata[STAT_SYNC_LOST] = pattern_sync_lost;
        next_rdata[STAT_ERR_NONZERO] = err_nonzero;
        next_rdata[STAT_UPDATE_DONE] = perf_monitor_update_done;
      end
      ADDR_LATCHED: begin
        next_rdata[STAT_SYNC_LOST] = lat_sync;
        next_rdata[STAT_ERR_NONZERO] = lat_nonzero;
        next_rdata[LAT_ERR_SEEN] = lat_err_seen;
        next_rdata[STAT_UPDATE_DONE] = lat_done;
      end
      ADDR_ERR_B0: next_rdata = err_shown[7:0];
      ADDR_ERR_B1: next_rdata = err_shown[15:8];
      ADDR_ERR_B2: next_rdata = err_shown[23:16];
      ADDR_BIT_B0: next_rdata = bits_shown[7:0];
      ADDR_BIT_B1: next_rdata = bits_shown[15:8];
      ADDR_BIT_B2: next_rdata = bits_shown[23:16];
      ADDR_BIT_B3: next_rdata = bits_shown[31:24];
      ADDR_RESET_CTRL: next_rdata = reset_ctrl;
      ADDR_LOOP_CTRL: next_rdata = loop_ctrl;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_rd) begin
      cpu_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // queue loopback datapath
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_ser_bit <= 1'b0;
      tx_ser_valid <= 1'b0;
    end else if (dp_rst) begin
      tx_ser_bit <= 1'b0;
      tx_ser_valid <= 1'b0;
    end else if (loop_on) begin
      tx_ser_bit <= rx_ser_bit;
      tx_ser_valid <= rx_ser_valid;
    end else begin
      tx_ser_bit <= tx_pkt_bit;
      tx_ser_valid <= tx_pkt_valid;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      eth_rx_bit <= 1'b0;
      eth_rx_valid <= 1'b0;
    end else if (dp_rst || loop_on) begin
      eth_rx_bit <= 1'b0;
      eth_rx_valid <= 1'b0;
    end else begin
      eth_rx_bit <= rx_ser_bit;
      eth_rx_valid <= rx_ser_valid;
    end
  end

  // queue sees the hold and keeps its packets until loopback ends
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      queue_hold <= 1'b0;
    end else begin
      queue_hold <= loop_on;
    end
  end

endmodule
`default_nettype wire

// ### shared/sbc_pkg.sv
// constants and types for the serial pattern-test counter and control bank
//
// Overview of operation
// - a 24-bit bit error tally, read as three bytes, low byte first
// - the error tally saturates at all ones and then stays there
// - the error tally does not advance while pattern sync is lost
// - a 32-bit received bit tally, read as four bytes, low byte first
// - the received bit tally saturates at all ones, never wraps
// - the received bit tally does not advance while pattern sync is lost
// - readable tallies refresh only on a rising update control edge
// - update-done status stays low for the whole refresh
// - refresh copies, clears, drops zero-count status one cycle, then sets done
// - events during a refresh are still counted, none lost
// - latched bits set on their event and clear when software reads them
// - a cleared latched bit sets again only on a new event
// - read-only bits ignore writes; other bits take written values; the code stores only the defined control bits, reserved bits stay zero
// - reset bit 1 of the reset register resets the interface datapath
// - the interface stays in reset while that bit is one
// - loopback bit 0 routes received serial data into the transmitter
// - during loopback received data is not forwarded to the Ethernet side
// - buffered packets stay queued during loopback, released after it ends
// - outside datapath reset, sync-lost flag is one exactly when the checker is not locked
// - update-done rises when a refresh completes, drops when the control drops
package sbc_pkg;

  localparam int ERR_W = 24;
  localparam int BIT_W = 32;
  localparam int CLK_PERIOD_PS = 5000;

  // register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h8c;
  localparam logic [7:0] ADDR_LATCHED = 8'h8e;
  localparam logic [7:0] ADDR_ERR_B0 = 8'h94;
  localparam logic [7:0] ADDR_ERR_B1 = 8'h95;
  localparam logic [7:0] ADDR_ERR_B2 = 8'h96;
  localparam logic [7:0] ADDR_BIT_B0 = 8'h98;
  localparam logic [7:0] ADDR_BIT_B1 = 8'h99;
  localparam logic [7:0] ADDR_BIT_B2 = 8'h9a;
  localparam logic [7:0] ADDR_BIT_B3 = 8'h9b;
  localparam logic [7:0] ADDR_RESET_CTRL = 8'hc1;
  localparam logic [7:0] ADDR_LOOP_CTRL = 8'hc2;

  // field positions
  localparam int STAT_SYNC_LOST = 0;
  localparam int STAT_ERR_NONZERO = 1;
  localparam int LAT_ERR_SEEN = 2;
  localparam int STAT_UPDATE_DONE = 3;
  localparam int RESET_CTRL_BIT = 1;
  localparam int LOOP_CTRL_BIT = 0;

  localparam logic [7:0] REG_RESET_VAL = 8'h00;

  // least hold time of the software reset, ns, and its cycle count (rounded up)
  localparam int RESET_MIN_NS = 200;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    PM_IDLE,
    PM_LOAD,
    PM_ZERO,
    PM_DONE
  } sbc_pm_state_t;

endpackage

// ### verilog/sbc_sync2.sv
// two-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sbc_sync2 (
  input wire logic ref_clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic din, // asynchronous level
  output logic dout // synchronised level
);
  logic meta;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// ### verilog/sbc_sat_counter.sv
// saturating event tally with freeze and a snapshot register
`timescale 1ns/1ps
`default_nettype none
module sbc_sat_counter #(
  parameter int W = 24
) (
  input wire logic ref_clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic clr, // synchronous datapath reset
  input wire logic inc, // one event this cycle
  input wire logic freeze, // hold the tally
  input wire logic snap, // copy tally out and restart it
  output logic [W-1:0] shown // readable snapshot
);
  logic [W-1:0] live;
  logic bump;

  // the byte-wide read mux serves at most four bytes
  if (W < 2 || W > 32) begin : g_bad_width
    $error("sbc_sat_counter: W out of range");
  end

  // saturation check stops the tally at all ones instead of wrapping
  assign bump = inc && !freeze && (live != {W{1'b1}});

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      live <= '0;
    end else if (clr) begin
      live <= '0;
    end else if (snap) begin
      // an event in the copy cycle starts the new tally at one
      live <= {{(W-1){1'b0}}, (inc && !freeze)};
    end else if (bump) begin
      live <= live + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shown <= '0;
    end else if (clr) begin
      shown <= '0;
    end else if (snap) begin
      shown <= live;
    end
  end
endmodule
`default_nettype wire

// ### tb/sbc_framer_model.sv
// behavioural far-side framer that feeds received bits to the counter bank
`timescale 1ns/1ps
`default_nettype none
module sbc_framer_model (
  input wire logic ref_clk, // system clock
  output logic rx_bit_valid, // one bit counted
  output logic rx_bit_error, // that bit errored
  output logic rx_ser_bit, // serial data
  output logic rx_ser_valid // serial valid
);
  // ********************
  // stream generator
  // ********************
  initial begin
    rx_bit_valid = 1'b0;
    rx_bit_error = 1'b0;
    rx_ser_bit = 1'b0;
    rx_ser_valid = 1'b0;
  end
  // data line toggles every cycle, so a stale value never passes for a looped bit
  always @(posedge ref_clk) begin
    rx_ser_bit <= ~rx_ser_bit;
  end
  task automatic send(input int n, input logic e);
    repeat (n) begin
      @(posedge ref_clk);
      rx_bit_valid <= 1'b1;
      rx_bit_error <= e;
      rx_ser_valid <= 1'b1;
    end
    @(posedge ref_clk);
    rx_bit_valid <= 1'b0;
    rx_bit_error <= 1'b0;
    rx_ser_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/sbc_top_properties.sv
// concurrent checks on the ports of the counter bank
`timescale 1ns/1ps
`default_nettype none
module sbc_top_properties (
  input wire logic ref_clk, // clock
  input wire logic resetn, // reset, low
  input wire logic [7:0] cpu_addr, // address
  input wire logic [7:0] cpu_wdata, // write data
  input wire logic cpu_wr, // write
  input wire logic cpu_rd, // read
  input wire logic [7:0] cpu_rdata, // read data
  input wire logic perf_monitor_update, // update
  input wire logic perf_monitor_update_done, // done
  input wire logic pattern_locked, // locked
  input wire logic pattern_sync_lost, // sync lost
  input wire logic rx_ser_bit, // rx bit
  input wire logic rx_ser_valid, // rx valid
  input wire logic tx_pkt_valid, // queue valid
  input wire logic tx_ser_bit, // tx bit
  input wire logic tx_ser_valid, // tx valid
  input wire logic eth_rx_valid, // eth valid
  input wire logic queue_hold, // queue stall
  input wire logic datapath_reset // interface reset
);
  // ********************
  // properties
  // ********************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  AST_SYNC_LOST: assert property (
    !datapath_reset && $past(resetn) |-> pattern_sync_lost == !$past(pattern_locked)
  ) else $error("sync lost flag wrong");
  AST_LOOP_TX: assert property (
    queue_hold && !datapath_reset && $past(rx_ser_valid) |-> tx_ser_valid && tx_ser_bit == $past(rx_ser_bit)
  ) else $error("looped bit wrong");
  AST_NO_FWD: assert property (
    queue_hold |-> !eth_rx_valid
  ) else $error("bit forwarded in loopback");
  AST_TX_PKT: assert property (
    !queue_hold && !datapath_reset |-> tx_ser_valid == $past(tx_pkt_valid)
  ) else $error("queue not released");
  AST_HOLD_WR: assert property (
    cpu_wr && cpu_addr == 8'hc2 |-> ##2 queue_hold == $past(cpu_wdata[0], 2)
  ) else $error("loopback write lost");
  AST_RD_LOOP: assert property (
    cpu_rd && cpu_addr == 8'hc2 |=> cpu_rdata == {7'h00, queue_hold}
  ) else $error("loopback read wrong");
  AST_SWRST: assert property (
    cpu_wr && cpu_addr == 8'hc1 && cpu_wdata[1] |-> ##2 datapath_reset [*3]
  ) else $error("interface reset missing");
  AST_DONE_EARLY: assert property (
    $rose(perf_monitor_update) ##1 perf_monitor_update [*4] |-> !perf_monitor_update_done
  ) else $error("done during refresh");
  AST_DONE_RISE: assert property (
    $rose(perf_monitor_update) && !datapath_reset ##1 (perf_monitor_update && !datapath_reset) [*6]
    |-> perf_monitor_update_done
  ) else $error("refresh never done");
  AST_DONE_FALL: assert property (
    !perf_monitor_update [*6] |-> !perf_monitor_update_done
  ) else $error("done stuck high");
endmodule
bind sbc_top sbc_top_properties u_props (
  .ref_clk(ref_clk), .resetn(resetn), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
  .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .perf_monitor_update(perf_monitor_update),
  .perf_monitor_update_done(perf_monitor_update_done), .pattern_locked(pattern_locked),
  .pattern_sync_lost(pattern_sync_lost), .rx_ser_bit(rx_ser_bit), .rx_ser_valid(rx_ser_valid),
  .tx_pkt_valid(tx_pkt_valid), .tx_ser_bit(tx_ser_bit), .tx_ser_valid(tx_ser_valid),
  .eth_rx_valid(eth_rx_valid), .queue_hold(queue_hold), .datapath_reset(datapath_reset)
);
`default_nettype wire

// ### tb/serial_bert_counters_ctrl_tb_top.sv
// self-checking bench for the pattern-test counter bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module serial_bert_counters_ctrl_tb_top;
  import sbc_pkg::*;
  // ********************
  // harness
  // ********************
  logic ref_clk, resetn, cpu_wr, cpu_rd, pmu, locked, pkt_bit, done, sync_lost, tx_bit, tx_valid;
  logic eth_bit, eth_valid, hold, dp_rst, bv, be, rbit, rvalid, pkt_valid;
  logic [7:0] addr, wdata, rdata, d;
  logic [23:0] ge, ge2;
  logic [31:0] gb, gb2;
  int n_fail, checks, cyc;
  sbc_top dut (
    .ref_clk(ref_clk), .resetn(resetn), .cpu_addr(addr), .cpu_wdata(wdata), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_rdata(rdata), .perf_monitor_update(pmu), .perf_monitor_update_done(done),
    .pattern_locked(locked), .rx_bit_valid(bv), .rx_bit_error(be), .pattern_sync_lost(sync_lost),
    .rx_ser_bit(rbit), .rx_ser_valid(rvalid), .tx_pkt_bit(pkt_bit), .tx_pkt_valid(pkt_valid),
    .tx_ser_bit(tx_bit), .tx_ser_valid(tx_valid), .eth_rx_bit(eth_bit), .eth_rx_valid(eth_valid),
    .queue_hold(hold), .datapath_reset(dp_rst)
  );
  sbc_framer_model fr (
    .ref_clk(ref_clk), .rx_bit_valid(bv), .rx_bit_error(be), .rx_ser_bit(rbit), .rx_ser_valid(rvalid)
  );
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    pkt_bit <= ~pkt_bit;
    pkt_valid <= cyc[1];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    cpu_wr <= 1'b1;
    @(posedge ref_clk);
    cpu_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    cpu_rd <= 1'b1;
    @(posedge ref_clk);
    cpu_rd <= 1'b0;
    @(posedge ref_clk);
    #1 v = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
    rd(a, d);
    `CHK(d, x)
  endtask
  task automatic get(output logic [23:0] e, output logic [31:0] b);
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_BIT_B0 + 8'(i), d);
      b[8*i +: 8] = d;
      if (i < 3) begin
        rd(ADDR_ERR_B0 + 8'(i), d);
        e[8*i +: 8] = d;
      end
    end
  endtask
  task automatic tallies(input logic [23:0] xe, input logic [31:0] xb);
    get(ge, gb);
    `CHK(ge, xe)
    `CHK(gb, xb)
  endtask
  // pin is held until done shows, then dropped until done clears
  task automatic refresh();
    int n;
    @(posedge ref_clk);
    pmu <= 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 30) begin
      @(posedge ref_clk);
      #1 n++;
    end
    `CHK(done, 1'b1)
    @(posedge ref_clk);
    pmu <= 1'b0;
    n = 0;
    while (done !== 1'b0 && n < 30) begin
      @(posedge ref_clk);
      #1 n++;
    end
    `CHK(done, 1'b0)
    repeat (4) @(posedge ref_clk);
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic t_defaults();
    tallies(24'h0, 32'h0);
    rd_chk(ADDR_RESET_CTRL, REG_RESET_VAL);
    rd_chk(ADDR_LOOP_CTRL, REG_RESET_VAL);
    rd_chk(ADDR_LATCHED, 8'h00);
  endtask
  task automatic t_count();
    fr.send(10, 1'b1);
    fr.send(5, 1'b0);
    refresh();
    tallies(24'd10, 32'd15);
    rd_chk(ADDR_STATUS, 8'h02);
    rd_chk(ADDR_LATCHED, 8'h0e);
    rd_chk(ADDR_LATCHED, 8'h00);
    refresh();
    tallies(24'h0, 32'h0);
    rd_chk(ADDR_LATCHED, 8'h08);
  endtask
  task automatic t_freeze();
    @(posedge ref_clk);
    locked <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(sync_lost, 1'b1)
    fr.send(7, 1'b1);
    @(posedge ref_clk);
    locked <= 1'b1;
    refresh();
    tallies(24'h0, 32'h0);
    rd_chk(ADDR_LATCHED, 8'h0d);
  endtask
  task automatic t_during();
    fork
      fr.send(30, 1'b0);
      refresh();
    join
    get(ge, gb);
    refresh();
    get(ge2, gb2);
    `CHK(gb + gb2, 32'd30)
  endtask
  task automatic t_regs();
    wr(ADDR_ERR_B0, 8'hff);
    rd_chk(ADDR_ERR_B0, 8'h00);
    wr(ADDR_LOOP_CTRL, 8'h01);
    wr(ADDR_LOOP_CTRL, 8'h00);
    rd_chk(ADDR_LOOP_CTRL, 8'h00);
    rd_chk(8'h80, 8'h00);
  endtask
  task automatic t_loop();
    logic prev, pb;
    wr(ADDR_LOOP_CTRL, 8'h01);
    rd_chk(ADDR_LOOP_CTRL, 8'h01);
    `CHK(hold, 1'b1)
    fork
      fr.send(6, 1'b0);
    join_none
    @(posedge ref_clk);
    #1 prev = rbit;
    repeat (4) begin
      @(posedge ref_clk);
      #1;
      `CHK(tx_bit, prev)
      `CHK(tx_valid, 1'b1)
      `CHK(eth_valid, 1'b0)
      prev = rbit;
    end
    wr(ADDR_LOOP_CTRL, 8'h00);
    @(posedge ref_clk);
    #1;
    `CHK(hold, 1'b0)
    prev = rbit;
    pb = pkt_bit;
    @(posedge ref_clk);
    #1;
    `CHK(eth_bit, prev)
    `CHK(tx_bit, pb)
  endtask
  task automatic t_swreset();
    int n;
    fr.send(5, 1'b1);
    refresh();
    wr(ADDR_RESET_CTRL, 8'h02);
    rd_chk(ADDR_RESET_CTRL, 8'h02);
    `CHK(dp_rst, 1'b1)
    repeat (RESET_MIN_CYC) @(posedge ref_clk);
    #1;
    `CHK(dp_rst, 1'b1)
    wr(ADDR_RESET_CTRL, 8'h00);
    n = 0;
    while (dp_rst !== 1'b0 && n < 100) begin
      @(posedge ref_clk);
      #1 n++;
    end
    `CHK(dp_rst, 1'b0)
    tallies(24'h0, 32'h0);
    rd_chk(ADDR_STATUS, 8'h00);
  endtask
  // ********************
  // main sequence
  // ********************
  initial begin
    resetn = 1'b0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    pmu = 1'b0;
    locked = 1'b1;
    pkt_bit = 1'b0;
    pkt_valid = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    n_fail = 0;
    checks = 0;
    cyc = 0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    t_defaults();
    t_count();
    t_freeze();
    t_during();
    t_regs();
    t_loop();
    t_swreset();
    report_and_stop();
  end
endmodule
`default_nettype wire
